// ### include/link_sup_pkg.sv
package link_sup_pkg;
	// =====================================================================
	// timing
	// =====================================================================
	localparam int unsigned MCLK_HZ = 200000000;
	localparam int unsigned WORK_HZ = 10000000;
	localparam int unsigned OSC_DIV = 2;
	// 20 MHz oscillator tick, then divide by two for the 10 MHz working tick
	localparam int unsigned OSC_CYC = MCLK_HZ / (WORK_HZ * OSC_DIV);
	localparam int unsigned TICK_PER_MS = WORK_HZ / 1000;
	localparam int unsigned LINKPULSE_MIN_MS = 8;
	localparam int unsigned LINKPULSE_MAX_MS = 24;
	localparam int unsigned PASS_MIN_MS = 750;
	localparam int unsigned PASS_MAX_MS = 1000;
	localparam int unsigned SUPPRESS_MS = 1200;
	// pulse interval chosen well inside the window
	localparam int unsigned LINKPULSE_TICKS = 16 * TICK_PER_MS;
	localparam int unsigned PASS_WIN_TICKS = PASS_MAX_MS * TICK_PER_MS;
	localparam int unsigned SUPPRESS_TICKS = SUPPRESS_MS * TICK_PER_MS;
	localparam int unsigned JABBER_TICKS = 26 * TICK_PER_MS;
	localparam int unsigned WATCHDOG_TICKS = 26 * TICK_PER_MS;
	localparam int unsigned SQ_MIN_TICKS = 1;
	localparam int unsigned SQ_MAX_TICKS = 3;
	localparam int unsigned SQ_SEQ_LEN = 3;
	localparam int unsigned LINK_PULSES_NEEDED = 2;
	localparam int unsigned TMR_W = 24;

	// =====================================================================
	// negotiation state field values
	// =====================================================================
	localparam logic [2:0] NEG_RESTART = 3'h1;
	localparam logic [2:0] NEG_DONE = 3'h5;
	localparam logic [2:0] NEG_IDLE = 3'h0;

	typedef enum logic [1:0] {
		DUP_NONE = 2'h0,
		DUP_HALF = 2'h1,
		DUP_FULL = 2'h2
	} duplex_t;

	// partner abilities as seen on the wire
	typedef struct packed {
		logic full;
		logic half;
	} ability_t;

	// closing word flags for a transmitted packet
	typedef struct packed {
		logic jabber_to;
		logic late_coll;
	} tx_close_t;
endpackage

// ### hdl/tick_div.sv
`timescale 1ns/1ps
// =====================================================================
// divider producing a one-cycle enable at the working rate
// =====================================================================
module tick_div
	import link_sup_pkg::*;
#(
	parameter int unsigned DIV = OSC_CYC * OSC_DIV
) (
	input wire logic clk,
	input wire logic rst,
	output logic tick
);
	initial begin
		if (DIV < 2 || DIV > 65536) $error("tick_div: DIV out of range");
	end
	logic [15:0] cnt_q, cnt_d;
	logic tick_d;
	// wrap counter, pulse on the last count
	always_comb begin
		tick_d = (cnt_q == 16'(DIV - 1));
		cnt_d = tick_d ? 16'h0000 : 16'(cnt_q + 16'h0001);
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 16'h0000;
			tick <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick <= tick_d;
		end
	end
endmodule // tick_div

// ### hdl/link_supervisor.sv
`timescale 1ns/1ps
// Summary of operation
// - jabber or watchdog expiry disables both paths
// - twisted-pair jabber cuts transmit, raises collision
// - jabber closes descriptor with jabber, late collision
// - squelch passes data after amplitude and sequence
// - squelch rejects too-short and too-long pulses
// - autopolarity inverts receive data when reversed
// - sense both ports; link pulses during AUI
// - pulse link pass, fail, timer expiry events
// - selected and nonselected activity bits, autosense enable
// - resolve full, half or no common mode
// - link must pass in window, else renegotiate
// - no common mode renegotiates after window
// - negotiation starts with 1.2 s pulse silence
// - advertise full duplex only when enabled
// - done reads 101, writing 001 restarts
// - link pulse every 8-24 ms when idle
// - reset enters link fail, pass enables paths
// - link fail raises event, stops paths at once
// - working clock is oscillator divided by two
module link_supervisor
	import link_sup_pkg::*;
#(
	parameter int unsigned JABBER_LIM = JABBER_TICKS,
	parameter int unsigned WATCHDOG_LIM = WATCHDOG_TICKS,
	parameter int unsigned SUPPRESS_LIM = SUPPRESS_TICKS,
	parameter int unsigned PASS_LIM = PASS_WIN_TICKS,
	parameter int unsigned PULSE_LIM = LINKPULSE_TICKS
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic SIU_RESET,
	input wire logic TP_SELECT,
	input wire logic AUTOSENSE_EN,
	input wire logic AUTONEG_EN,
	input wire logic AUTOPOL_EN,
	input wire logic FULL_DUPLEX_EN,
	input wire logic NEG_RESTART_WR,
	input wire logic TX_ACTIVE,
	input wire logic RX_ACTIVE,
	input wire logic TP_RX_AMPLITUDE_OK,
	input wire logic TP_RX_PULSE,
	input wire logic TP_RX_DATA,
	input wire logic TP_LINK_PULSE,
	input wire logic TP_LINK_PULSE_INV,
	input wire logic AUI_ACTIVITY,
	input wire ability_t PARTNER_ABILITY,
	input wire logic PARTNER_ABILITY_VALID,
	input wire logic GP_TIMER_EXPIRED,
	output logic TX_PATH_EN,
	output logic RX_PATH_EN,
	output logic TX_CUTOFF,
	output logic COLLISION,
	output tx_close_t TX_CLOSE_FLAGS,
	output logic TX_CLOSE_STB,
	output logic RX_DATA_TO_DEC,
	output logic RX_DATA_VALID,
	output logic POLARITY_REVERSED,
	output logic LINK_PULSE_OUT,
	output logic ADV_FULL_DUPLEX,
	output logic SELECTED_ACTIVITY,
	output logic NONSELECTED_ACTIVITY,
	output logic LINK_PASS_EVT,
	output logic LINK_FAIL_EVT,
	output logic TIMER_EXP_EVT,
	output logic NEG_DONE_EVT,
	output logic [2:0] NEG_STATE,
	output duplex_t DUPLEX_MODE
);
	initial begin
		if (JABBER_LIM == 0 || WATCHDOG_LIM == 0 || SUPPRESS_LIM == 0 ||
			PASS_LIM == 0 || PULSE_LIM == 0)
			$error("link_supervisor: timer limits must be nonzero");
		if (SUPPRESS_LIM >= (1 << TMR_W) || PASS_LIM >= (1 << TMR_W))
			$error("link_supervisor: limit exceeds timer width");
	end

	// =====================================================================
	// working tick
	// =====================================================================
	logic tick;
	// one-cycle enable at 10 MHz, oscillator rate divided by two
	tick_div #(.DIV(OSC_CYC * OSC_DIV)) u_div (
		.clk(MCLK),
		.rst(RST),
		.tick(tick)
	);

	// =====================================================================
	// link state machine
	// =====================================================================
	typedef enum logic [4:0] {
		ST_FAIL = 5'h01,
		ST_SILENT = 5'h02,
		ST_NEGOT = 5'h04,
		ST_CHECK = 5'h08,
		ST_PASS = 5'h10
	} lstate_t;

	lstate_t st_q, st_d;
	logic [TMR_W-1:0] tmr_q, tmr_d;
	logic [1:0] lp_cnt_q, lp_cnt_d;
	duplex_t dup_q, dup_d;
	logic [2:0] neg_q, neg_d;
	logic pol_q, pol_d;
	logic lp_seen;
	logic jab_trip, wd_trip;
	logic fail_now;

	assign lp_seen = TP_LINK_PULSE | TP_LINK_PULSE_INV;

	// mode resolution from partner abilities and local enable
	function automatic duplex_t resolve(input ability_t p, input logic fd);
		if (p.full && fd)
			resolve = DUP_FULL;
		else if (p.half)
			resolve = DUP_HALF;
		else
			resolve = DUP_NONE;
	endfunction

	// timeouts or unit reset force link fail
	assign fail_now = jab_trip | wd_trip | SIU_RESET;

	always_comb begin
		st_d = st_q;
		tmr_d = tmr_q;
		lp_cnt_d = lp_cnt_q;
		dup_d = dup_q;
		neg_d = neg_q;
		pol_d = pol_q;
		// polarity learnt from pulses of either sense
		if (AUTOPOL_EN && TP_SELECT && (st_q != ST_PASS)) begin
			if (TP_LINK_PULSE_INV)
				pol_d = 1'b1;
			else if (TP_LINK_PULSE)
				pol_d = 1'b0;
		end else if (!AUTOPOL_EN) begin
			pol_d = 1'b0;
		end
		if (tick && tmr_q != '0)
			tmr_d = TMR_W'(tmr_q - 1'b1);
		unique case (st_q)
			ST_FAIL: begin
				// fail state sends pulses, waits for line activity
				if (lp_seen)
					lp_cnt_d = 2'(lp_cnt_q + 2'h1);
				if (AUTONEG_EN && TP_SELECT) begin
					st_d = ST_SILENT;
					tmr_d = TMR_W'(SUPPRESS_LIM);
					neg_d = NEG_RESTART;
				end else if (lp_cnt_q >= 2'(LINK_PULSES_NEEDED)) begin
					st_d = ST_PASS;
					dup_d = DUP_HALF;
				end
			end
			ST_SILENT: begin
				if (tmr_q == '0) begin
					st_d = ST_NEGOT;
					neg_d = 3'h3;
				end
			end
			ST_NEGOT: begin
				if (PARTNER_ABILITY_VALID) begin
					dup_d = resolve(PARTNER_ABILITY, FULL_DUPLEX_EN);
					neg_d = NEG_DONE;
					st_d = ST_CHECK;
					tmr_d = TMR_W'(PASS_LIM);
					lp_cnt_d = 2'h0;
				end
			end
			ST_CHECK: begin
				if (lp_seen)
					lp_cnt_d = 2'(lp_cnt_q + 2'h1);
				if (dup_q != DUP_NONE &&
					lp_cnt_q >= 2'(LINK_PULSES_NEEDED)) begin
					st_d = ST_PASS;
				end else if (tmr_q == '0) begin
					// no pass in window, or no common mode
					st_d = ST_SILENT;
					tmr_d = TMR_W'(SUPPRESS_LIM);
					neg_d = NEG_RESTART;
				end
			end
			ST_PASS: begin
				lp_cnt_d = 2'h0;
			end
			default: st_d = ST_FAIL;
		endcase
		// software restart of negotiation
		if (NEG_RESTART_WR && AUTONEG_EN && st_q != ST_FAIL) begin
			st_d = ST_SILENT;
			tmr_d = TMR_W'(SUPPRESS_LIM);
			neg_d = NEG_RESTART;
		end
		if (fail_now || (st_q == ST_PASS && !TP_SELECT)) begin
			st_d = ST_FAIL;
			lp_cnt_d = 2'h0;
			tmr_d = '0;
			neg_d = NEG_IDLE;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			st_q <= ST_FAIL;
			tmr_q <= '0;
			lp_cnt_q <= 2'h0;
			dup_q <= DUP_NONE;
			neg_q <= NEG_IDLE;
			pol_q <= 1'b0;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			lp_cnt_q <= lp_cnt_d;
			dup_q <= dup_d;
			neg_q <= neg_d;
			pol_q <= pol_d;
		end
	end

	// =====================================================================
	// jabber, watchdog and link pulse timers
	// =====================================================================
	logic [TMR_W-1:0] jab_q, jab_d, wd_q, wd_d, lp_q, lp_d;
	logic jab_hold_q, jab_hold_d;
	logic lp_fire;

	always_comb begin
		jab_d = jab_q;
		wd_d = wd_q;
		lp_d = lp_q;
		lp_fire = 1'b0;
		jab_hold_d = jab_hold_q && TX_ACTIVE;
		if (!TX_ACTIVE)
			jab_d = '0;
		else if (tick && !jab_hold_q)
			jab_d = TMR_W'(jab_q + 1'b1);
		if (!RX_ACTIVE)
			wd_d = '0;
		else if (tick && wd_q != TMR_W'(WATCHDOG_LIM))
			wd_d = TMR_W'(wd_q + 1'b1);
		if (jab_trip)
			jab_hold_d = 1'b1;
		// pulse timer runs except while transmitting on twisted pair in link pass
		if (TX_ACTIVE && st_q == ST_PASS && TP_SELECT)
			lp_d = '0;
		else if (tick) begin
			if (lp_q >= TMR_W'(PULSE_LIM - 1)) begin
				lp_d = '0;
				lp_fire = 1'b1;
			end else
				lp_d = TMR_W'(lp_q + 1'b1);
		end
	end
	assign jab_trip = TX_ACTIVE && !jab_hold_q &&
		jab_q >= TMR_W'(JABBER_LIM);
	assign wd_trip = RX_ACTIVE && wd_q == TMR_W'(WATCHDOG_LIM);

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			jab_q <= '0;
			wd_q <= '0;
			lp_q <= '0;
			jab_hold_q <= 1'b0;
		end else begin
			jab_q <= jab_d;
			wd_q <= wd_d;
			lp_q <= lp_d;
			jab_hold_q <= jab_hold_d;
		end
	end

	// =====================================================================
	// smart squelch
	// =====================================================================
	// one spare count above the longest good width, so over-long pulses show
	logic [2:0] pw_q, pw_d;
	logic [1:0] seq_q, seq_d;
	logic pulse_prev_q;
	logic sq_open;

	// width measured in ticks; bad widths restart the sequence
	always_comb begin
		pw_d = pw_q;
		seq_d = seq_q;
		if (!TP_RX_AMPLITUDE_OK) begin
			pw_d = 3'h0;
			seq_d = 2'h0;
		end else if (TP_RX_PULSE) begin
			if (tick && pw_q <= 3'(SQ_MAX_TICKS))
				pw_d = 3'(pw_q + 3'h1);
			if (pw_q > 3'(SQ_MAX_TICKS))
				seq_d = 2'h0;
		end else if (pulse_prev_q) begin
			pw_d = 3'h0;
			if (pw_q < 3'(SQ_MIN_TICKS) || pw_q > 3'(SQ_MAX_TICKS))
				seq_d = 2'h0;
			else if (seq_q != 2'(SQ_SEQ_LEN))
				seq_d = 2'(seq_q + 2'h1);
		end
	end
	assign sq_open = TP_RX_AMPLITUDE_OK && seq_q == 2'(SQ_SEQ_LEN);

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			pw_q <= 3'h0;
			seq_q <= 2'h0;
			pulse_prev_q <= 1'b0;
		end else begin
			pw_q <= pw_d;
			seq_q <= seq_d;
			pulse_prev_q <= TP_RX_PULSE;
		end
	end

	// =====================================================================
	// registered outputs
	// =====================================================================
	logic pass_now;
	assign pass_now = (st_q == ST_PASS);

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			TX_PATH_EN <= 1'b0;
			RX_PATH_EN <= 1'b0;
			TX_CUTOFF <= 1'b0;
			COLLISION <= 1'b0;
			TX_CLOSE_FLAGS <= '0;
			TX_CLOSE_STB <= 1'b0;
			RX_DATA_TO_DEC <= 1'b0;
			RX_DATA_VALID <= 1'b0;
			POLARITY_REVERSED <= 1'b0;
			LINK_PULSE_OUT <= 1'b0;
			ADV_FULL_DUPLEX <= 1'b0;
			SELECTED_ACTIVITY <= 1'b0;
			NONSELECTED_ACTIVITY <= 1'b0;
			LINK_PASS_EVT <= 1'b0;
			LINK_FAIL_EVT <= 1'b0;
			TIMER_EXP_EVT <= 1'b0;
			NEG_DONE_EVT <= 1'b0;
			NEG_STATE <= NEG_IDLE;
			DUPLEX_MODE <= DUP_NONE;
		end else begin
			// paths drop the cycle after any fail cause
			TX_PATH_EN <= (st_d == ST_PASS) && !fail_now;
			RX_PATH_EN <= (st_d == ST_PASS) && !fail_now;
			TX_CUTOFF <= jab_hold_d && TP_SELECT;
			COLLISION <= jab_hold_d && TP_SELECT;
			TX_CLOSE_FLAGS <= jab_trip ? 2'b11 : 2'b00;
			TX_CLOSE_STB <= jab_trip;
			RX_DATA_TO_DEC <= sq_open & (TP_RX_DATA ^ pol_q);
			RX_DATA_VALID <= sq_open && TP_SELECT;
			POLARITY_REVERSED <= pol_q;
			// pulses go out even while the coax port is carrying data
			LINK_PULSE_OUT <= lp_fire && st_q != ST_SILENT;
			ADV_FULL_DUPLEX <= FULL_DUPLEX_EN;
			// both ports are watched at once
			SELECTED_ACTIVITY <= AUTOSENSE_EN &&
				(TP_SELECT ? sq_open : AUI_ACTIVITY);
			NONSELECTED_ACTIVITY <= AUTOSENSE_EN &&
				(TP_SELECT ? AUI_ACTIVITY : sq_open);
			LINK_PASS_EVT <= (st_d == ST_PASS) && !pass_now;
			LINK_FAIL_EVT <= (st_d == ST_FAIL) && pass_now;
			TIMER_EXP_EVT <= GP_TIMER_EXPIRED;
			NEG_DONE_EVT <= (neg_d == NEG_DONE) && (neg_q != NEG_DONE);
			NEG_STATE <= neg_d;
			DUPLEX_MODE <= dup_d;
		end
	end
endmodule // link_supervisor

// ### dv/link_partner.sv
`timescale 1ns/1ps
// =====================================================================
// remote twisted-pair partner: link pulses and ability word
// =====================================================================
module link_partner
	import link_sup_pkg::*;
#(
	parameter int unsigned GAP = 200
) (
	input wire logic clk,
	input wire logic en,
	input wire logic rev,
	input wire ability_t adv,
	output logic lp,
	output logic lp_inv,
	output ability_t ability,
	output logic ability_vld
);
	int cnt = 0;
	// quiet lines at time zero, before the first falling edge
	initial begin
		{lp, lp_inv, ability_vld, ability} = '0;
	end
	// pulse train; the word rides on each pulse, garbage between them
	always @(negedge clk) begin
		cnt <= (cnt + 1) % GAP;
		lp <= en && !rev && cnt == 0;
		lp_inv <= en && rev && cnt == 0;
		ability_vld <= en && cnt == 0;
		ability <= (en && cnt == 0) ? adv : ~ability;
	end
endmodule // link_partner

// ### dv/link_supervisor_chk.sv
`timescale 1ns/1ps
// =====================================================================
// port-level checks of the link supervisor
// =====================================================================
module link_supervisor_chk
	import link_sup_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic SIU_RESET,
	input wire logic TP_SELECT,
	input wire logic FULL_DUPLEX_EN,
	input wire logic TP_RX_AMPLITUDE_OK,
	input wire logic TX_PATH_EN,
	input wire logic RX_PATH_EN,
	input wire logic TX_CUTOFF,
	input wire logic COLLISION,
	input wire tx_close_t TX_CLOSE_FLAGS,
	input wire logic TX_CLOSE_STB,
	input wire logic RX_DATA_VALID,
	input wire logic LINK_PULSE_OUT,
	input wire logic ADV_FULL_DUPLEX,
	input wire logic LINK_PASS_EVT,
	input wire logic LINK_FAIL_EVT,
	input wire logic NEG_DONE_EVT,
	input wire logic [2:0] NEG_STATE,
	input wire duplex_t DUPLEX_MODE
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	// =====================================================================
	// assertions
	// =====================================================================
	chk_jab_close: assert property (TX_CLOSE_STB |-> TX_CLOSE_FLAGS == 2'h3)
		else $error("jabber close flags wrong");
	chk_jab_coll: assert property (TX_CLOSE_STB && TP_SELECT |-> COLLISION && TX_CUTOFF)
		else $error("jabber without collision");
	chk_path_pair: assert property (TX_PATH_EN == RX_PATH_EN)
		else $error("paths not switched together");
	chk_fail_stop: assert property (LINK_FAIL_EVT |-> !TX_PATH_EN && !RX_PATH_EN)
		else $error("paths open at link fail");
	chk_pass_open: assert property (LINK_PASS_EVT |-> TX_PATH_EN && RX_PATH_EN)
		else $error("paths closed at link pass");
	chk_adv_full: assert property (!FULL_DUPLEX_EN [*2] |-> !ADV_FULL_DUPLEX)
		else $error("full duplex advertised while off");
	chk_full_need: assert property (DUPLEX_MODE == DUP_FULL |-> ADV_FULL_DUPLEX)
		else $error("full duplex without local enable");
	chk_neg_done: assert property (NEG_DONE_EVT |-> ##[0:1] NEG_STATE == NEG_DONE)
		else $error("done event without done field");
	chk_pulse_gap: assert property (LINK_PULSE_OUT |=> !LINK_PULSE_OUT [*8])
		else $error("link pulses too close");
	chk_siu_fail: assert property (SIU_RESET [*2] |-> !TX_PATH_EN)
		else $error("path open during unit reset");
	chk_squelch_amp: assert property (!TP_RX_AMPLITUDE_OK [*2] |-> !RX_DATA_VALID)
		else $error("data passed below threshold");
	// main scenarios reached
	cov_pass: cover property (LINK_PASS_EVT);
	cov_jab: cover property (TX_CLOSE_STB);
	cov_full: cover property (NEG_DONE_EVT && DUPLEX_MODE == DUP_FULL);
	cov_squelch: cover property (RX_DATA_VALID);
endmodule // link_supervisor_chk

// ### dv/tb_link_supervisor.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
	err_count++; $display("MISMATCH %s exp=%0h got=%0h", n, e, g); end end
module tb_link_supervisor
	import link_sup_pkg::*;
;
	localparam int TK = OSC_CYC * OSC_DIV;
	localparam int LIM = 50;
	localparam int SUP = 20;
	localparam int PUL = 10;
	logic MCLK = 1'b0;
	logic RST = 1'b1;
	logic siu = 1'b0, sel = 1'b1, asen = 1'b1, neg = 1'b0, apol = 1'b1;
	logic fd = 1'b0, rsw = 1'b0, txa = 1'b0, rxa = 1'b0, aui = 1'b0;
	logic gpt = 1'b0, pen = 1'b0, prev = 1'b0;
	ability_t padv = '0, pab;
	logic lp, lpi, pvld, txen, rxen, cut, col, stb, prv, lpo, adv, sa, nsa;
	logic pass, fail, texp, ndone;
	logic amp = 1'b0, rpul = 1'b0, rdat = 1'b0, rdv, rdd;
	logic [2:0] nst;
	tx_close_t flags;
	duplex_t dup;
	int err_count = 0, compares = 0, k;
	// short limits keep every count in the tens of ticks
	link_supervisor #(.JABBER_LIM(LIM), .WATCHDOG_LIM(LIM),
		.SUPPRESS_LIM(SUP), .PASS_LIM(LIM), .PULSE_LIM(PUL)) DUT (
		.MCLK, .RST, .SIU_RESET(siu), .TP_SELECT(sel), .AUTOSENSE_EN(asen),
		.AUTONEG_EN(neg), .AUTOPOL_EN(apol), .FULL_DUPLEX_EN(fd),
		.NEG_RESTART_WR(rsw), .TX_ACTIVE(txa), .RX_ACTIVE(rxa),
		.TP_RX_AMPLITUDE_OK(amp), .TP_RX_PULSE(rpul), .TP_RX_DATA(rdat),
		.TP_LINK_PULSE(lp), .TP_LINK_PULSE_INV(lpi), .AUI_ACTIVITY(aui),
		.PARTNER_ABILITY(pab), .PARTNER_ABILITY_VALID(pvld),
		.GP_TIMER_EXPIRED(gpt), .TX_PATH_EN(txen), .RX_PATH_EN(rxen),
		.TX_CUTOFF(cut), .COLLISION(col), .TX_CLOSE_FLAGS(flags),
		.TX_CLOSE_STB(stb), .RX_DATA_TO_DEC(rdd), .RX_DATA_VALID(rdv),
		.POLARITY_REVERSED(prv), .LINK_PULSE_OUT(lpo), .ADV_FULL_DUPLEX(adv),
		.SELECTED_ACTIVITY(sa), .NONSELECTED_ACTIVITY(nsa),
		.LINK_PASS_EVT(pass), .LINK_FAIL_EVT(fail), .TIMER_EXP_EVT(texp),
		.NEG_DONE_EVT(ndone), .NEG_STATE(nst), .DUPLEX_MODE(dup));
	link_partner u_partner (.clk(MCLK), .en(pen), .rev(prev), .adv(padv),
		.lp(lp), .lp_inv(lpi), .ability(pab), .ability_vld(pvld));
	always #2.5 MCLK = ~MCLK;
	// =====================================================================
	// shared tasks
	// =====================================================================
	task automatic wt(ref logic s, input int n);
		for (k = 0; k < n && s !== 1'b1; k++) @(negedge MCLK);
	endtask
	task rst_dut;
		RST = 1'b1;
		repeat (8) @(negedge MCLK);
		RST = 1'b0;
	endtask
	task final_report;
		if (err_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// =====================================================================
	// scenarios
	// =====================================================================
	// idle link-fail pulse spacing, paths held shut
	task t_pulses;
		wt(lpo, 3 * PUL * TK);
		@(negedge MCLK);
		wt(lpo, 3 * PUL * TK);
		`CHK("gap", 1'b1, k + 1 >= PUL * TK - 1 && k + 1 <= PUL * TK + 1)
		`CHK("txen fail", 1'b0, txen)
	endtask
	// plain link pass, with or without reversed wires
	task t_pass(input logic rev);
		prev = rev;
		pen = 1'b1;
		wt(pass, 2000);
		`CHK("pass", 1'b1, pass)
		`CHK("rxen", 1'b1, rxen)
		`CHK("polarity", rev, prv)
	endtask
	// one receive pulse of w cycles, then a short gap
	task automatic sq_pulse(input int w);
		rpul = 1'b1;
		repeat (w) @(negedge MCLK);
		rpul = 1'b0;
		repeat (3) @(negedge MCLK);
	endtask
	// squelch opens on three good pulses, closes on noise
	task t_squelch;
		amp = 1'b1;
		for (int i = 0; i < 3; i++) begin
			`CHK("sq shut", 1'b0, rdv)
			sq_pulse(2 * TK);
		end
		`CHK("sq open", 1'b1, rdv & rdd & sa)
		apol = 1'b0;
		asen = 1'b0;
		repeat (3) @(negedge MCLK);
		`CHK("pol off", 1'b0, rdd | prv | sa)
		apol = 1'b1;
		asen = 1'b1;
		sq_pulse(6 * TK);
		`CHK("sq long", 1'b0, rdv)
		for (int i = 0; i < 3; i++)
			sq_pulse(2 * TK);
		`CHK("sq reopen", 1'b1, rdv)
		amp = 1'b0;
		repeat (2) @(negedge MCLK);
		`CHK("sq amp", 1'b0, rdv)
	endtask
	// over-long transmit or receive packet
	task t_over(input logic rx);
		txa = !rx;
		rxa = rx;
		wt(fail, LIM * TK + 100);
		`CHK("fail", 1'b1, fail)
		`CHK("late", 1'b1, k >= (LIM - 1) * TK)
		`CHK("paths", 1'b0, txen | rxen)
		`CHK("close", !rx, stb)
		`CHK("flags", rx ? 2'h0 : 2'h3, flags)
		`CHK("coll", !rx, col & cut)
		txa = 1'b0;
		rxa = 1'b0;
		wt(pass, 2000);
		`CHK("repass", 1'b1, pass)
	endtask
	// unit reset forces link fail
	task t_siu;
		siu = 1'b1;
		wt(fail, 20);
		`CHK("siu fail", 1'b1, fail & !txen)
		siu = 1'b0;
		wt(pass, 2000);
		`CHK("siu pass", 1'b1, pass)
	endtask
	// activity bits, pulses while on coax, timer event
	task t_sense;
		aui = 1'b1;
		repeat (2) @(negedge MCLK);
		`CHK("nonsel", 1'b1, nsa)
		sel = 1'b0;
		repeat (2) @(negedge MCLK);
		`CHK("sel act", 1'b1, sa)
		// coax port sending: twisted-pair pulses must keep going
		txa = 1'b1;
		wt(lpo, 3 * PUL * TK);
		`CHK("aui pulse", 1'b1, lpo)
		txa = 1'b0;
		gpt = 1'b1;
		@(negedge MCLK);
		gpt = 1'b0;
		wt(texp, 3);
		`CHK("timer", 1'b1, texp)
		aui = 1'b0;
		sel = 1'b1;
	endtask
	// five rows of the duplex resolution table, covering all three outcomes
	task t_neg;
		logic [4:0] tbl [5];
		int n;
		tbl = '{5'h16, 5'h0D, 5'h19, 5'h10, 5'h04};
		for (int i = 0; i < 5; i++) begin
			{padv, fd} = tbl[i][4:2];
			neg = 1'b1;
			rst_dut();
			n = 0;
			repeat (SUP * TK - TK) begin
				@(negedge MCLK);
				n += lpo;
			end
			`CHK("silent", 0, n)
			wt(ndone, 3000);
			`CHK("field", NEG_DONE, nst)
			`CHK("duplex", tbl[i][1:0], dup)
			`CHK("adv", fd, adv)
			if (tbl[i][1:0] != 2'h0) begin
				wt(pass, LIM * TK + 100);
				`CHK("neg pass", 1'b1, pass & txen)
			end else begin
				for (k = 0; k < LIM * TK + 100 && nst !== NEG_RESTART; k++)
					@(negedge MCLK);
				`CHK("renego", 1'b0, txen | (nst !== NEG_RESTART))
				`CHK("renego time", 1'b1, k >= (LIM - 1) * TK)
			end
			if (i == 0) begin
				rsw = 1'b1;
				@(negedge MCLK);
				rsw = 1'b0;
				repeat (2) @(negedge MCLK);
				`CHK("restart", NEG_RESTART, nst)
			end
		end
	endtask
	// =====================================================================
	// main sequence and watchdog
	// =====================================================================
	initial begin
		rst_dut();
		t_pulses();
		t_pass(1'b1);
		t_squelch();
		t_over(1'b0);
		t_over(1'b1);
		t_siu();
		t_sense();
		t_neg();
		final_report();
	end
	// the full run needs about a quarter of this span
	initial begin
		#200000;
		err_count++;
		final_report();
	end
endmodule // tb_link_supervisor
bind link_supervisor link_supervisor_chk u_chk (.MCLK, .RST, .SIU_RESET,
	.TP_SELECT, .FULL_DUPLEX_EN, .TP_RX_AMPLITUDE_OK, .TX_PATH_EN,
	.RX_PATH_EN, .TX_CUTOFF, .COLLISION, .TX_CLOSE_FLAGS, .TX_CLOSE_STB,
	.RX_DATA_VALID, .LINK_PULSE_OUT, .ADV_FULL_DUPLEX, .LINK_PASS_EVT,
	.LINK_FAIL_EVT, .NEG_DONE_EVT, .NEG_STATE, .DUPLEX_MODE);
